/* File: bcp_pkg.sv */
package bcp_pkg;

  // clock
  localparam int CLK_PERIOD_NS = 10;

  // tach pulse width and pwm oscillator period, in ns
  localparam int TACH_PULSE_NS = 113000;
  localparam int OSC_PERIOD_NS = 67500;

  // cycle counts (tach: minimum time, rounded up; osc: rounded down)
  localparam int TACH_PULSE_CYC = (TACH_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int OSC_PERIOD_CYC = OSC_PERIOD_NS / CLK_PERIOD_NS;

  // register byte addresses
  localparam logic [4:0] REG_CTRL_ADDR = 5'h00;
  localparam logic [4:0] REG_STATUS_ADDR = 5'h04;
  localparam logic [4:0] REG_IRQ_STAT_ADDR = 5'h08;
  localparam logic [4:0] REG_IRQ_MASK_ADDR = 5'h0C;

  // control fields
  localparam int CTRL_SW_COAST_BIT = 0;
  localparam logic [31:0] CTRL_RESET = 32'h0000_0000;

  // status fields
  localparam int ST_HALL_LSB = 0;
  localparam int ST_DIR_LATCH_BIT = 3;
  localparam int ST_SHIFT_LSB = 4;
  localparam int ST_SOFTSTART_BIT = 6;
  localparam int ST_TACH_BIT = 7;
  localparam int ST_PWM_LATCH_BIT = 8;
  localparam int ST_INHIBIT_BIT = 9;
  localparam int ST_BRAKE_BIT = 10;

  // interrupt events
  localparam int IRQ_W = 6;
  localparam int IRQ_OVERCURRENT = 0;
  localparam int IRQ_UNDERVOLT = 1;
  localparam int IRQ_COAST = 2;
  localparam int IRQ_BRAKE = 3;
  localparam int IRQ_TACH = 4;
  localparam int IRQ_PEAK_LIMIT = 5;
  localparam logic [IRQ_W-1:0] IRQ_MASK_RESET = 6'h00;

  typedef enum logic [1:0] {
    BCP_HIZ,
    BCP_SOURCE,
    BCP_SINK
  } bcp_phase_t;

  // comparator and threshold outputs from the analog front end
  typedef struct packed {
    logic brake_low;
    logic coast_high;
    logic supply_low;
    logic over_current;
    logic ss_cap_low;
    logic speed_high;
    logic peak_current;
    logic pwm_comp_trip;
  } bcp_sense_t;

  // gate drive of one phase
  typedef struct packed {
    logic hi_on;
    logic lo_on;
  } bcp_gate_t;

endpackage

/* File: bcp_commutate.sv */
`timescale 1ns/1ps
module bcp_commutate (
  // position and direction
  input wire logic [2:0] hall,
  input wire logic dir,
  // per-phase state a, b, c
  output bcp_pkg::bcp_phase_t ph_a,
  output bcp_pkg::bcp_phase_t ph_b,
  output bcp_pkg::bcp_phase_t ph_c
);

  function automatic bcp_pkg::bcp_phase_t flip(input bcp_pkg::bcp_phase_t p, input logic d);
    if (d || p == bcp_pkg::BCP_HIZ) begin
      flip = p;
    end else if (p == bcp_pkg::BCP_SOURCE) begin
      flip = bcp_pkg::BCP_SINK;
    end else begin
      flip = bcp_pkg::BCP_SOURCE;
    end
  endfunction

  bcp_pkg::bcp_phase_t a_fwd;
  bcp_pkg::bcp_phase_t b_fwd;
  bcp_pkg::bcp_phase_t c_fwd;

  // R15 six-step decode
  always_comb begin
    a_fwd = bcp_pkg::BCP_HIZ;
    b_fwd = bcp_pkg::BCP_HIZ;
    c_fwd = bcp_pkg::BCP_HIZ;
    case (hall)
      3'h1: begin
        b_fwd = bcp_pkg::BCP_SINK;
        c_fwd = bcp_pkg::BCP_SOURCE;
      end
      3'h3: begin
        a_fwd = bcp_pkg::BCP_SINK;
        c_fwd = bcp_pkg::BCP_SOURCE;
      end
      3'h2: begin
        a_fwd = bcp_pkg::BCP_SINK;
        b_fwd = bcp_pkg::BCP_SOURCE;
      end
      3'h6: begin
        b_fwd = bcp_pkg::BCP_SOURCE;
        c_fwd = bcp_pkg::BCP_SINK;
      end
      3'h4: begin
        a_fwd = bcp_pkg::BCP_SOURCE;
        c_fwd = bcp_pkg::BCP_SINK;
      end
      3'h5: begin
        a_fwd = bcp_pkg::BCP_SOURCE;
        b_fwd = bcp_pkg::BCP_SINK;
      end
      // illegal codes 000 and 111 stay all high impedance
      default: begin
        a_fwd = bcp_pkg::BCP_HIZ;
      end
    endcase
  end

  // R10 reverse direction swaps source and sink
  assign ph_a = flip(a_fwd, dir);
  assign ph_b = flip(b_fwd, dir);
  assign ph_c = flip(c_fwd, dir);

endmodule // bcp_commutate

/* File: bcp_top.sv */
// Summary of operation
// R1 - brake: high sides off, low sides on
// R2 - coast input puts all phases Hi-Z
// R3 - undervoltage or overcurrent sets soft-start latch
// R4 - latch clears when capacitor low, no fault
// R5 - direction latch transparent only at low speed
// R6 - direction passes 2-bit oscillator-clocked shift register
// R7 - direction mismatch forces all phases Hi-Z
// R8 - pull-up and pull-down never both on
// R9 - peak current ends chopping this cycle
// R10 - phases source or sink per commutation decode
// R11 - chop select: low sides or all six
// R12 - hall change: fixed tach pulse, hall frozen
// R13 - pwm comparator clears pwm latch
// R14 - overcurrent disables outputs until removed
// R15 - six-step decode, illegal hall codes Hi-Z
// R16 - inhibits win over brake and commutation
//
// Our own choices: the Avalon-MM register port and the address map.
`timescale 1ns/1ps
module bcp_top #(
  parameter int TACH_CYC = bcp_pkg::TACH_PULSE_CYC,
  parameter int OSC_CYC = bcp_pkg::OSC_PERIOD_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // avalon-mm slave
  input wire logic [4:0] avs_address,
  input wire logic avs_read,
  input wire logic avs_write,
  input wire logic [31:0] avs_writedata,
  output logic [31:0] avs_readdata,
  output logic avs_waitrequest,
  // motor inputs
  input wire logic hall_sense_a,
  input wire logic hall_sense_b,
  input wire logic hall_sense_c,
  input wire logic dir_in,
  input wire logic chop_mode_sel,
  input wire bcp_pkg::bcp_sense_t sense,
  // phase drives and status pins
  output bcp_pkg::bcp_gate_t gate_a,
  output bcp_pkg::bcp_gate_t gate_b,
  output bcp_pkg::bcp_gate_t gate_c,
  output logic tach_out,
  output logic ss_discharge,
  output logic irq
);

  localparam int OSC_W = $clog2(OSC_CYC + 1);
  localparam int TACH_W = $clog2(TACH_CYC + 1);

  function automatic bcp_pkg::bcp_gate_t gate_of(input bcp_pkg::bcp_phase_t p, input logic pwm_on,
                                                 input logic full_chop);
    gate_of.hi_on = (p == bcp_pkg::BCP_SOURCE) && (pwm_on || !full_chop);
    gate_of.lo_on = (p == bcp_pkg::BCP_SINK) && pwm_on;
  endfunction

  // register write strobe, shared by the writable registers
  function automatic logic wr_hit(input logic take, input logic [4:0] addr, input logic [4:0] reg_addr);
    wr_hit = take && (addr == reg_addr);
  endfunction

  logic [OSC_W-1:0] osc_cnt_r;
  logic osc_tick;
  logic [2:0] hall_in;
  logic [2:0] hall_lat_r;
  logic [TACH_W-1:0] tach_cnt_r;
  logic tach_active;
  logic hall_change;
  logic ss_latch_r;
  logic dir_lat_r;
  logic [1:0] dir_sh_r;
  logic dir_mismatch;
  logic pwm_lat_r;
  logic sw_coast_r;
  logic inhibit;
  logic [bcp_pkg::IRQ_W-1:0] irq_stat_r;
  logic [bcp_pkg::IRQ_W-1:0] irq_mask_r;
  logic [bcp_pkg::IRQ_W-1:0] ev_level;
  logic [bcp_pkg::IRQ_W-1:0] ev_prev_r;
  logic [bcp_pkg::IRQ_W-1:0] ev_pulse;
  logic ack_r;
  logic bus_take;
  logic [31:0] status_word;
  bcp_pkg::bcp_phase_t ph_a;
  bcp_pkg::bcp_phase_t ph_b;
  bcp_pkg::bcp_phase_t ph_c;

  // pwm oscillator as a one-cycle enable
  always_ff @(posedge mclk) begin
    if (reset || osc_tick) begin
      osc_cnt_r <= '0;
    end else begin
      osc_cnt_r <= osc_cnt_r + OSC_W'(1);
    end
  end
  assign osc_tick = (osc_cnt_r == OSC_W'(OSC_CYC - 1));

  // R12 tach pulse and hall freeze
  assign hall_in = {hall_sense_a, hall_sense_b, hall_sense_c};
  assign tach_active = (tach_cnt_r != '0);
  assign hall_change = !tach_active && (hall_in != hall_lat_r);

  always_ff @(posedge mclk) begin
    if (reset) begin
      hall_lat_r <= 3'h0;
    end else if (hall_change) begin
      hall_lat_r <= hall_in;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      tach_cnt_r <= '0;
    end else if (hall_change) begin
      tach_cnt_r <= TACH_W'(TACH_CYC);
    end else if (tach_active) begin
      tach_cnt_r <= tach_cnt_r - TACH_W'(1);
    end
  end

  // R3 set on undervoltage or overcurrent; set wins
  // R4 clear only with capacitor low and no fault
  // reset sets it, so every start passes through a discharge
  always_ff @(posedge mclk) begin
    if (reset) begin
      ss_latch_r <= 1'b1;
    end else if (sense.supply_low || sense.over_current) begin
      ss_latch_r <= 1'b1;
    end else if (sense.ss_cap_low) begin
      ss_latch_r <= 1'b0;
    end
  end

  // R5 direction latch gated by speed
  always_ff @(posedge mclk) begin
    if (reset) begin
      dir_lat_r <= 1'b0;
    end else if (!sense.speed_high) begin
      dir_lat_r <= dir_in;
    end
  end

  // R6 shift register on oscillator ticks
  always_ff @(posedge mclk) begin
    if (reset) begin
      dir_sh_r <= 2'h0;
    end else if (osc_tick) begin
      dir_sh_r <= {dir_sh_r[0], dir_lat_r};
    end
  end

  // R7 mismatch across latch or shift stages
  // a reversal refused at speed keeps the phases off
  assign dir_mismatch = (dir_in != dir_lat_r) || (dir_lat_r != dir_sh_r[0]) || (dir_sh_r[0] != dir_sh_r[1]);

  // R13 comparator clears, oscillator sets
  // R9 peak current ends chopping for the cycle
  always_ff @(posedge mclk) begin
    if (reset) begin
      pwm_lat_r <= 1'b0;
    end else if (sense.pwm_comp_trip || sense.peak_current) begin
      pwm_lat_r <= 1'b0;
    end else if (osc_tick) begin
      pwm_lat_r <= 1'b1;
    end
  end

  bcp_commutate u_commutate (
    .hall(hall_lat_r),
    .dir(dir_sh_r[1]),
    .ph_a(ph_a),
    .ph_b(ph_b),
    .ph_c(ph_c)
  );

  // R2 coast, R14 live overcurrent, R7 mismatch
  assign inhibit = sense.coast_high || sw_coast_r || ss_latch_r || sense.over_current || dir_mismatch;

  // R16 inhibit first, then brake, then commutation
  always_ff @(posedge mclk) begin
    if (reset || inhibit) begin
      gate_a <= '0;
      gate_b <= '0;
      gate_c <= '0;
    end else if (sense.brake_low) begin
      // R1 brake, R11 chop select ignored here
      gate_a <= 2'h1;
      gate_b <= 2'h1;
      gate_c <= 2'h1;
    end else begin
      // R10 R11 R8 drive per decoded phase
      gate_a <= gate_of(ph_a, pwm_lat_r, chop_mode_sel);
      gate_b <= gate_of(ph_b, pwm_lat_r, chop_mode_sel);
      gate_c <= gate_of(ph_c, pwm_lat_r, chop_mode_sel);
    end
  end

  // tach_out high for TACH_CYC cycles from acceptance
  always_ff @(posedge mclk) begin
    if (reset) begin
      tach_out <= 1'b0;
      ss_discharge <= 1'b1;
    end else begin
      tach_out <= hall_change || (tach_cnt_r > TACH_W'(1));
      ss_discharge <= ss_latch_r;
    end
  end

  // interrupt events on rising edges
  always_comb begin
    ev_level = '0;
    ev_level[bcp_pkg::IRQ_OVERCURRENT] = sense.over_current;
    ev_level[bcp_pkg::IRQ_UNDERVOLT] = sense.supply_low;
    ev_level[bcp_pkg::IRQ_COAST] = sense.coast_high;
    ev_level[bcp_pkg::IRQ_BRAKE] = sense.brake_low;
    ev_level[bcp_pkg::IRQ_TACH] = hall_change;
    ev_level[bcp_pkg::IRQ_PEAK_LIMIT] = sense.peak_current;
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      ev_prev_r <= '0;
    end else begin
      ev_prev_r <= ev_level;
    end
  end
  assign ev_pulse = ev_level & ~ev_prev_r;

  // avalon slave: one wait cycle per access
  assign bus_take = (avs_read || avs_write) && !ack_r;
  assign avs_waitrequest = (avs_read || avs_write) && !ack_r;

  // ack_r marks the second cycle of a request
  always_ff @(posedge mclk) begin
    if (reset) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= bus_take;
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      sw_coast_r <= bcp_pkg::CTRL_RESET[bcp_pkg::CTRL_SW_COAST_BIT];
    end else if (wr_hit(ack_r && avs_write, avs_address, bcp_pkg::REG_CTRL_ADDR)) begin
      sw_coast_r <= avs_writedata[bcp_pkg::CTRL_SW_COAST_BIT];
    end
  end

  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_mask_r <= bcp_pkg::IRQ_MASK_RESET;
    end else if (wr_hit(ack_r && avs_write, avs_address, bcp_pkg::REG_IRQ_MASK_ADDR)) begin
      irq_mask_r <= avs_writedata[bcp_pkg::IRQ_W-1:0];
    end
  end

  // write one to clear; a new event wins over the clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq_stat_r <= '0;
    end else if (wr_hit(ack_r && avs_write, avs_address, bcp_pkg::REG_IRQ_STAT_ADDR)) begin
      irq_stat_r <= (irq_stat_r & ~avs_writedata[bcp_pkg::IRQ_W-1:0]) | ev_pulse;
    end else begin
      irq_stat_r <= irq_stat_r | ev_pulse;
    end
  end

  // level interrupt, one cycle behind the status bits
  always_ff @(posedge mclk) begin
    if (reset) begin
      irq <= 1'b0;
    end else begin
      irq <= |(irq_stat_r & irq_mask_r);
    end
  end

  // read-only status snapshot
  always_comb begin
    status_word = '0;
    status_word[bcp_pkg::ST_HALL_LSB +: 3] = hall_lat_r;
    status_word[bcp_pkg::ST_DIR_LATCH_BIT] = dir_lat_r;
    status_word[bcp_pkg::ST_SHIFT_LSB +: 2] = dir_sh_r;
    status_word[bcp_pkg::ST_SOFTSTART_BIT] = ss_latch_r;
    status_word[bcp_pkg::ST_TACH_BIT] = tach_active;
    status_word[bcp_pkg::ST_PWM_LATCH_BIT] = pwm_lat_r;
    status_word[bcp_pkg::ST_INHIBIT_BIT] = inhibit;
    status_word[bcp_pkg::ST_BRAKE_BIT] = sense.brake_low;
  end

  // read data is loaded in the cycle the request is taken
  always_ff @(posedge mclk) begin
    if (reset) begin
      avs_readdata <= '0;
    end else if (bus_take && avs_read) begin
      case (avs_address)
        bcp_pkg::REG_CTRL_ADDR: avs_readdata <= {31'h0, sw_coast_r};
        bcp_pkg::REG_STATUS_ADDR: avs_readdata <= status_word;
        bcp_pkg::REG_IRQ_STAT_ADDR: avs_readdata <= {26'h0, irq_stat_r};
        bcp_pkg::REG_IRQ_MASK_ADDR: avs_readdata <= {26'h0, irq_mask_r};
        default: avs_readdata <= 32'h0000_0000;
      endcase
    end
  end

endmodule // bcp_top

/* File: bcp_motor_model.sv */
`timescale 1ns/1ps
module bcp_motor_model (
  // clock and stepping
  input wire logic mclk,
  input wire logic step,
  input wire logic [1:0] bad,
  // hall sensors
  output logic hall_sense_a,
  output logic hall_sense_b,
  output logic hall_sense_c
);
  logic [2:0] pos_r = 3'h0;
  logic [2:0] code;
  // gray order, one sensor changes per step
  always_comb begin
    case (pos_r)
      3'h0: code = 3'h1;
      3'h1: code = 3'h3;
      3'h2: code = 3'h2;
      3'h3: code = 3'h6;
      3'h4: code = 3'h4;
      default: code = 3'h5;
    endcase
  end
  always_ff @(posedge mclk) begin
    if (step) begin
      pos_r <= (pos_r == 3'h5) ? 3'h0 : pos_r + 3'h1;
    end
  end
  // bad[1] gives an all-equal sensor fault
  assign {hall_sense_a, hall_sense_b, hall_sense_c} = bad[1] ? {3{bad[0]}} : code;
endmodule // bcp_motor_model

/* File: bcp_top_properties.sv */
`timescale 1ns/1ps
module bcp_top_properties #(
  parameter int TACH_CYC = bcp_pkg::TACH_PULSE_CYC
) (
  // clock and reset
  input wire logic mclk,
  input wire logic reset,
  // motor side
  input wire bcp_pkg::bcp_sense_t sense,
  input wire bcp_pkg::bcp_gate_t gate_a,
  input wire bcp_pkg::bcp_gate_t gate_b,
  input wire bcp_pkg::bcp_gate_t gate_c,
  input wire logic tach_out,
  input wire logic ss_discharge
);
  logic [15:0] tcnt_r;
  wire logic hi_any = gate_a.hi_on | gate_b.hi_on | gate_c.hi_on;
  wire logic lo_any = gate_a.lo_on | gate_b.lo_on | gate_c.lo_on;
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  // length of the current tach pulse
  always_ff @(posedge mclk) begin
    if (reset || !tach_out) begin
      tcnt_r <= 16'h0000;
    end else begin
      tcnt_r <= tcnt_r + 16'h0001;
    end
  end
  property p_cross;
    !(gate_a.hi_on && gate_a.lo_on) && !(gate_b.hi_on && gate_b.lo_on) && !(gate_c.hi_on && gate_c.lo_on);
  endproperty
  a_cross: assert property (p_cross) else $error("phase cross conduction");
  property p_coast;
    sense.coast_high |=> !hi_any && !lo_any;
  endproperty
  a_coast: assert property (p_coast) else $error("coast not hi-z");
  property p_brake;
    sense.brake_low |=> !hi_any;
  endproperty
  a_brake: assert property (p_brake) else $error("high side on in brake");
  property p_ocur;
    sense.over_current |=> !hi_any && !lo_any;
  endproperty
  a_ocur: assert property (p_ocur) else $error("overcurrent not hi-z");
  property p_ss_set;
    (sense.over_current || sense.supply_low) |-> ##[1:2] ss_discharge;
  endproperty
  a_ss_set: assert property (p_ss_set) else $error("soft-start not set");
  property p_ss_clr;
    !sense.ss_cap_low ##1 (!sense.ss_cap_low && ss_discharge) |=> ss_discharge;
  endproperty
  a_ss_clr: assert property (p_ss_clr) else $error("soft-start cleared early");
  property p_chop;
    ((sense.pwm_comp_trip || sense.peak_current) && !sense.brake_low)[*2] |=> !lo_any;
  endproperty
  a_chop: assert property (p_chop) else $error("chop not ended");
  property p_tach;
    $fell(tach_out) |-> tcnt_r == TACH_CYC;
  endproperty
  a_tach: assert property (p_tach) else $error("tach width wrong");
endmodule // bcp_top_properties
bind bcp_top bcp_top_properties #(.TACH_CYC(TACH_CYC)) u_props (.mclk(mclk), .reset(reset), .sense(sense),
  .gate_a(gate_a), .gate_b(gate_b), .gate_c(gate_c), .tach_out(tach_out), .ss_discharge(ss_discharge));

/* File: bcp_top_tb.sv */
`timescale 1ns/1ps
module bcp_top_tb;
  localparam int TC = 20;
  localparam int OC = 8;
  logic mclk = 1'h0;
  logic reset = 1'h1;
  logic [4:0] avs_address = 5'h00;
  logic avs_read = 1'h0;
  logic avs_write = 1'h0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic avs_waitrequest;
  logic dir_in = 1'h0;
  logic chop_mode_sel = 1'h0;
  bcp_pkg::bcp_sense_t sense = '0;
  logic step = 1'h0;
  logic [1:0] bad = 2'h2;
  logic hall_sense_a, hall_sense_b, hall_sense_c, tach_out, ss_discharge, irq;
  bcp_pkg::bcp_gate_t gate_a, gate_b, gate_c;
  wire logic [5:0] g = {gate_a, gate_b, gate_c};
  logic [31:0] q;
  logic [2:0] seq [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
  int failures = 0;
  int n_tests = 0;
  always #5 mclk = ~mclk;
  bcp_motor_model u_motor (.mclk(mclk), .step(step), .bad(bad), .hall_sense_a(hall_sense_a),
    .hall_sense_b(hall_sense_b), .hall_sense_c(hall_sense_c));
  bcp_top #(.TACH_CYC(TC), .OSC_CYC(OC)) uut (.mclk(mclk), .reset(reset), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_readdata(avs_readdata),
    .avs_waitrequest(avs_waitrequest), .hall_sense_a(hall_sense_a), .hall_sense_b(hall_sense_b),
    .hall_sense_c(hall_sense_c), .dir_in(dir_in), .chop_mode_sel(chop_mode_sel), .sense(sense),
    .gate_a(gate_a), .gate_b(gate_b), .gate_c(gate_c), .tach_out(tach_out), .ss_discharge(ss_discharge),
    .irq(irq));
  task automatic finish_test();
    $display("tests %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("[ PASS ]");
    end else begin
      $display("[ FAIL ]");
    end
    $finish;
  endtask
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    n_tests++;
    if (s !== e) begin
      failures++;
      $display("Error %s expected %h seen %h", nm, e, s);
    end
  endtask
  task automatic w(input int n);
    repeat (n) @(posedge mclk);
  endtask
  // values seen right after an edge are those that stood at it
  task automatic bus(input logic wr, input logic [4:0] a, input logic [31:0] d);
    int n;
    n = 0;
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= wr;
    avs_read <= !wr;
    do begin
      @(posedge mclk);
      n++;
    end while (avs_waitrequest !== 1'h0 && n < 50);
    if (n >= 50) begin
      failures++;
      finish_test();
    end
    q = avs_readdata;
    avs_read <= 1'h0;
    avs_write <= 1'h0;
    @(posedge mclk);
  endtask
  // six-step table, reverse swaps source and sink
  function automatic logic [5:0] ex(input logic [2:0] h, input logic d);
    logic [5:0] t;
    case (h)
      3'h1: t = 6'h06;
      3'h3: t = 6'h12;
      3'h2: t = 6'h18;
      3'h6: t = 6'h09;
      3'h4: t = 6'h21;
      3'h5: t = 6'h24;
      default: t = 6'h00;
    endcase
    return d ? t : {t[4], t[5], t[2], t[3], t[0], t[1]};
  endfunction
  initial begin
    w(4);
    reset <= 1'h0;
    w(1);
    bus(1'h0, bcp_pkg::REG_CTRL_ADDR, 32'h0);
    chk("ctrl", 32'h0, q);
    bus(1'h0, 5'h10, 32'h0);
    chk("unmapped", 32'h0, q);
    bus(1'h0, bcp_pkg::REG_STATUS_ADDR, 32'h0);
    chk("ss latch", 32'h1, {31'h0, q[bcp_pkg::ST_SOFTSTART_BIT]});
    sense.ss_cap_low <= 1'h1;
    w(3);
    sense.ss_cap_low <= 1'h0;
    w(3);
    chk("ss_discharge", 32'h0, ss_discharge);
    bad <= 2'h0;
    for (int i = 0; i < 6; i++) begin
      if (i > 0) begin
        step <= 1'h1;
        w(1);
        step <= 1'h0;
      end
      w(3);
      chk("tach", 32'h1, tach_out);
      w(TC + OC);
      chk("decode", ex(seq[i], 1'h0), g);
    end
    step <= 1'h1;
    w(1);
    step <= 1'h0;
    w(3);
    step <= 1'h1;
    w(1);
    step <= 1'h0;
    bus(1'h0, bcp_pkg::REG_STATUS_ADDR, 32'h0);
    chk("hall frozen", 32'h1, {29'h0, q[2:0]});
    w(TC + OC);
    chk("late hall", ex(3'h3, 1'h0), g);
    bad <= 2'h3;
    w(TC + 4);
    chk("hall 111", 32'h0, g);
    bad <= 2'h2;
    w(TC + 4);
    chk("hall 000", 32'h0, g);
    bad <= 2'h0;
    w(TC + 4);
    dir_in <= 1'h1;
    w(3);
    chk("reverse hiz", 32'h0, g);
    w(2 * OC + 4);
    chk("reverse", ex(3'h3, 1'h1), g);
    sense.speed_high <= 1'h1;
    dir_in <= 1'h0;
    w(4);
    bus(1'h0, bcp_pkg::REG_STATUS_ADDR, 32'h0);
    chk("dir hold", 32'h1, {31'h0, q[bcp_pkg::ST_DIR_LATCH_BIT]});
    chk("hold hiz", 32'h0, g);
    dir_in <= 1'h1;
    sense.speed_high <= 1'h0;
    w(4);
    chk("hold end", ex(3'h3, 1'h1), g);
    sense.pwm_comp_trip <= 1'h1;
    w(3);
    chk("half chop", ex(3'h3, 1'h1) & 6'h2A, g);
    chop_mode_sel <= 1'h1;
    w(3);
    chk("full chop", 32'h0, g);
    sense.pwm_comp_trip <= 1'h0;
    sense.peak_current <= 1'h1;
    w(OC + 2);
    chk("peak", 32'h0, g);
    sense.peak_current <= 1'h0;
    sense.brake_low <= 1'h1;
    w(3);
    chk("brake", 6'h15, g);
    chop_mode_sel <= 1'h0;
    w(3);
    chk("brake sel", 6'h15, g);
    sense.coast_high <= 1'h1;
    w(3);
    chk("coast", 32'h0, g);
    sense.brake_low <= 1'h0;
    sense.coast_high <= 1'h0;
    bus(1'h1, bcp_pkg::REG_IRQ_STAT_ADDR, 32'h3F);
    bus(1'h1, bcp_pkg::REG_IRQ_MASK_ADDR, 32'h4);
    chk("irq idle", 32'h0, irq);
    sense.coast_high <= 1'h1;
    w(2);
    sense.coast_high <= 1'h0;
    w(3);
    chk("irq", 32'h1, irq);
    bus(1'h0, bcp_pkg::REG_IRQ_STAT_ADDR, 32'h0);
    chk("irq stat", 32'h4, q);
    bus(1'h1, bcp_pkg::REG_IRQ_STAT_ADDR, 32'h4);
    sense.brake_low <= 1'h1;
    w(3);
    sense.brake_low <= 1'h0;
    w(2);
    chk("irq masked", 32'h0, irq);
    bus(1'h1, bcp_pkg::REG_CTRL_ADDR, 32'h1);
    w(2);
    chk("sw coast", 32'h0, g);
    bus(1'h1, bcp_pkg::REG_CTRL_ADDR, 32'h0);
    sense.over_current <= 1'h1;
    w(3);
    chk("ocur", 32'h0, g);
    chk("ocur ss", 32'h1, ss_discharge);
    sense.over_current <= 1'h0;
    w(4);
    chk("ocur held", 32'h0, g);
    sense.ss_cap_low <= 1'h1;
    w(3);
    sense.ss_cap_low <= 1'h0;
    w(OC + 4);
    chk("restart", ex(3'h3, 1'h1), g);
    sense.supply_low <= 1'h1;
    w(3);
    chk("uv ss", 32'h1, ss_discharge);
    finish_test();
  end
  initial begin
    w(5000);
    failures++;
    finish_test();
  end
endmodule // bcp_top_tb
